/* ptr_chk.sv */
`timescale 1ns/100ps
// ****************************************************************
// Port checker for the command, fault and conversion outputs
// ****************************************************************
module ptr_chk
	import ptr_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_rd_req,
	input  wire logic        i_wr_req,
	input  wire logic [7:0]  i_cmd,
	input  wire logic [7:0]  i_wr_data,
	input  wire logic        o_rd_ack,
	input  wire logic [15:0] o_rd_data,
	input  wire logic [1:0]  o_rd_byte_count,
	input  wire logic        o_cmd_err,
	input  wire logic        o_cml_fault,
	input  wire logic        o_conv_start
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic rd_ok;   // Read code this block answers
	logic sel_wr;  // Write aimed at the selector
	logic sel_bad; // Selector value is reserved
	assign rd_ok = i_cmd inside {8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'h95, 8'h96,
		8'h97, 8'hd7, 8'hd8, 8'hdd, 8'hde, 8'hdf, 8'he1, 8'he4, 8'hf4};
	assign sel_wr = i_wr_req && (i_cmd == CMD_SAMPLING_MODE_SELECT);
	assign sel_bad = !(i_wr_data inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
		8'h08, 8'h09, 8'h0a, 8'h0c});
	// Selector writes left alone for one more cycle, so the fault can settle
	sequence s_bad_sel;
		sel_wr && sel_bad ##1 !sel_wr;
	endsequence
	sequence s_good_sel;
		sel_wr && !sel_bad ##1 !sel_wr;
	endsequence
	a_read_acked: assert property (i_rd_req && rd_ok |=> o_rd_ack && !o_cmd_err)
		else $error("supported read not acknowledged");
	a_read_refused: assert property (i_rd_req && !rd_ok |=> o_cmd_err && !o_rd_ack)
		else $error("unsupported read not refused");
	a_write_refused: assert property (i_wr_req && !sel_wr |=> o_cmd_err && !o_rd_ack)
		else $error("write to read-only code not refused");
	a_word_count: assert property (i_rd_req && rd_ok && !(i_cmd == 8'hd8) |=>
		o_rd_byte_count == 2'd2) else $error("word result not two bytes");
	a_byte_count: assert property (i_rd_req && i_cmd == 8'hd8 |=> o_rd_byte_count == 2'd1)
		else $error("selector read not one byte");
	a_fault_raised: assert property (s_bad_sel |=> o_cml_fault)
		else $error("reserved selector raised no fault");
	a_fault_dropped: assert property (s_good_sel |=> !o_cml_fault)
		else $error("fault stays after valid selector");
	a_data_held: assert property (!o_rd_ack |-> $stable(o_rd_data))
		else $error("read word moved without a read");
	a_ack_cause: assert property (o_rd_ack |-> $past(i_rd_req))
		else $error("acknowledge without request");
	a_conv_single: assert property (o_conv_start |=> !o_conv_start)
		else $error("conversion start longer than one cycle");
endmodule

/* ptr_front_model.sv */
`timescale 1ns/100ps
// Front end stand-in: answers each conversion start with one sample
module ptr_front_model (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_conv_start,
	input  wire logic [3:0]         i_conv_sel,
	input  wire logic signed [15:0] i_value,
	output logic                    o_smp_valid,
	output logic [3:0]              o_smp_sel,
	output logic signed [15:0]      o_smp_data
);
	logic [1:0] delay; // Conversion latency pipe
	// Sample lands three cycles after the start; data scrambles between samples
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			delay <= 2'b00;
			o_smp_valid <= 1'b0;
			o_smp_data <= 16'sh5a5a;
		end else begin
			delay <= {delay[0], i_conv_start};
			o_smp_valid <= delay[1];
			o_smp_data <= delay[1] ? i_value : ~o_smp_data;
		end
		o_smp_sel <= i_conv_sel;
	end
endmodule

/* ptr_pkg.sv */
package ptr_pkg;

	// ****************************************************************
	// Command codes of the telemetry results and the sampling mode selector
	// ****************************************************************
	localparam logic [7:0] CMD_INPUT_VOLTAGE_READING        = 8'h88;
	localparam logic [7:0] CMD_INPUT_CURRENT_READING        = 8'h89;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_READING       = 8'h8b;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_READING       = 8'h8c;
	localparam logic [7:0] CMD_EXTERNAL_TEMPERATURE_READING = 8'h8d;
	localparam logic [7:0] CMD_DIE_TEMPERATURE_READING      = 8'h8e;
	localparam logic [7:0] CMD_SWITCHING_FREQUENCY_READING  = 8'h95;
	localparam logic [7:0] CMD_OUTPUT_POWER_READING         = 8'h96;
	localparam logic [7:0] CMD_INPUT_POWER_READING          = 8'h97;
	localparam logic [7:0] CMD_OUTPUT_CURRENT_MAXIMUM       = 8'hd7;
	localparam logic [7:0] CMD_SAMPLING_MODE_SELECT         = 8'hd8;
	localparam logic [7:0] CMD_OUTPUT_VOLTAGE_MAXIMUM       = 8'hdd;
	localparam logic [7:0] CMD_INPUT_VOLTAGE_MAXIMUM        = 8'hde;
	localparam logic [7:0] CMD_EXTERNAL_TEMPERATURE_MAXIMUM = 8'hdf;
	localparam logic [7:0] CMD_INPUT_CURRENT_MAXIMUM        = 8'he1;
	localparam logic [7:0] CMD_CHIP_SUPPLY_CURRENT          = 8'he4;
	localparam logic [7:0] CMD_DIE_TEMPERATURE_MAXIMUM      = 8'hf4;

	// Reset value of the sampling mode selector
	localparam logic [7:0] SAMPLING_MODE_RESET = 8'h00;

	// ****************************************************************
	// Parameter codes shared by selector, conversion and sample ports
	// ****************************************************************
	localparam logic [3:0] SEL_ROUND_ROBIN = 4'h0;
	localparam logic [3:0] SEL_VIN         = 4'h1;
	localparam logic [3:0] SEL_ICHIP       = 4'h2;
	localparam logic [3:0] SEL_IIN         = 4'h3;
	localparam logic [3:0] SEL_DIE         = 4'h4;
	localparam logic [3:0] SEL_VOUT0       = 4'h5;
	localparam logic [3:0] SEL_IOUT0       = 4'h6;
	localparam logic [3:0] SEL_FREQ0       = 4'h7;
	localparam logic [3:0] SEL_TEMP0       = 4'h8;
	localparam logic [3:0] SEL_VOUT1       = 4'h9;
	localparam logic [3:0] SEL_IOUT1       = 4'ha;
	localparam logic [3:0] SEL_FREQ1       = 4'hb;
	localparam logic [3:0] SEL_TEMP1       = 4'hc;

	// ****************************************************************
	// Number formats and fixed-point scaling
	// ****************************************************************
	typedef enum logic [1:0] {FMT_NONE, FMT_L11, FMT_L16, FMT_BYTE} ptr_fmt_t;
	typedef enum logic [1:0] {MODE_ROUND_ROBIN, MODE_SINGLE, MODE_FALLBACK} ptr_mode_t;

	localparam logic signed [5:0]  EXP_FINE     = -6'sd8;
	localparam logic signed [5:0]  EXP_FREQ     = 6'sd0;
	localparam logic signed [5:0]  EXP_MAX      = 6'sd15;
	localparam logic signed [6:0]  VOUT_RAW_FRAC = 7'sd12;
	localparam logic signed [31:0] MANT_MAX     = 32'sd1023;
	localparam logic signed [31:0] MANT_MIN     = -32'sd1024;
	localparam logic signed [31:0] L16_MAX      = 32'sd65535;
	localparam logic signed [31:0] PEAK_FLOOR   = 32'sh8000_0000;
	localparam int                 L11_STEPS    = 22;
	localparam int                 TEMP_FRAC    = 8;
	localparam int                 TEMP_REF_C   = 27;
	localparam logic signed [31:0] TEMP_REF     = 32'(TEMP_REF_C << TEMP_FRAC);
	localparam int                 RVIN_SHIFT   = 10;
	localparam int                 IIN_SHIFT    = 12;
	localparam int                 COND_SHIFT   = 20;
	localparam int                 TGAIN_SHIFT  = 14;
	localparam int                 TC_SHIFT     = 20;
	localparam int                 POUT_SHIFT   = 12;
	localparam int                 PIN_SHIFT    = 8;
	localparam logic [1:0]         BYTES_WORD   = 2'd2;
	localparam logic [1:0]         BYTES_BYTE   = 2'd1;
	localparam logic [1:0]         BYTES_NONE   = 2'd0;

	// ****************************************************************
	// Conversion scheduling times
	// ****************************************************************
	localparam int CLK_HZ         = 50_000_000;
	localparam int RR_CYCLE_MS    = 90;
	localparam int FAST_UPDATE_MS = 8;
	localparam int RR_SLOTS       = 10;
	localparam int RR_SLOT_CYC    = CLK_HZ / 1000 * RR_CYCLE_MS / RR_SLOTS;
	localparam int FAST_SLOT_CYC  = CLK_HZ / 1000 * FAST_UPDATE_MS;
	localparam int SLOT_W         = 20;
	localparam logic [3:0] RR_LAST = 4'd9;

endpackage

/* ptr_telemetry_readback.sv */
`timescale 1ns/100ps
// ****************************************************************
// ****************************************************************
module ptr_telemetry_readback
	import ptr_pkg::*;
#(
	parameter int P_RR_SLOT_CYC   = RR_SLOT_CYC,
	parameter int P_FAST_SLOT_CYC = FAST_SLOT_CYC
) (
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic               i_rd_req,
	input  wire logic               i_wr_req,
	input  wire logic [7:0]         i_cmd,
	input  wire logic               i_page,
	input  wire logic [7:0]         i_wr_data,
	input  wire logic               i_clear_peaks_command,
	output logic                    o_rd_ack,
	output logic [15:0]             o_rd_data,
	output logic [1:0]              o_rd_byte_count,
	output logic                    o_cmd_err,
	output logic                    o_cml_fault,
	input  wire logic               i_smp_valid,
	input  wire logic [3:0]         i_smp_sel,
	input  wire logic signed [15:0] i_smp_data,
	output logic                    o_conv_start,
	output logic [3:0]              o_conv_sel,
	input  wire logic [15:0]        i_input_filter_resistance,
	input  wire logic [15:0]        i_input_current_sense_gain,
	input  wire logic [15:0]        i_current_sense_conductance,
	input  wire logic signed [15:0] i_current_gain_temp_coefficient,
	input  wire logic [15:0]        i_external_sensor_gain,
	input  wire logic signed [15:0] i_external_sensor_offset,
	input  wire logic signed [4:0]  i_vout_mode_exponent
);

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Fixed-point product with arithmetic right shift back to 32 bits
	function automatic logic signed [31:0] mul_shr(input logic signed [31:0] a,
			input logic signed [31:0] b, input int sh);
		logic signed [63:0] p;
		p = (64'(a) * 64'(b)) >>> sh;
		return p[31:0];
	endfunction

	// Linear 11-bit encode: shift mantissa into range, bump exponent
	function automatic logic [15:0] enc_l11(input logic signed [31:0] v,
			input logic signed [5:0] e);
		logic signed [31:0] m;
		logic signed [5:0]  x;
		m = v;
		x = e;
		for (int k = 0; k < L11_STEPS; k++) begin
			if (m > MANT_MAX || m < MANT_MIN) begin
				m = m >>> 1;
				x = x + 6'sd1;
			end
		end
		// Saturate rather than wrap the exponent field
		if (x > EXP_MAX) begin
			x = EXP_MAX;
			m = (v < 0) ? MANT_MIN : MANT_MAX;
		end
		return {x[4:0], m[10:0]};
	endfunction

	// Unsigned 16-bit encode at the configured output exponent
	function automatic logic [15:0] enc_l16(input logic signed [31:0] v,
			input logic signed [4:0] n);
		logic signed [6:0]  sh;
		logic signed [31:0] u;
		sh = {{2{n[4]}}, n} + VOUT_RAW_FRAC;
		if (sh >= 0) begin
			u = v >>> sh;
		end else begin
			u = v <<< (-sh);
		end
		// Negative readings clamp to zero, overrange to all ones
		if (u < 0) begin
			return 16'h0000;
		end else if (u > L16_MAX) begin
			return 16'hffff;
		end
		return u[15:0];
	endfunction

	// Peak hold: clear drops to floor, a same-cycle sample still wins
	function automatic logic signed [31:0] peak_next(input logic signed [31:0] old,
			input logic clr, input logic hit, input logic signed [31:0] val);
		logic signed [31:0] base;
		base = clr ? PEAK_FLOOR : old;
		return (hit && val > base) ? val : base;
	endfunction

	// Round-robin order of the converted parameters
	function automatic logic [3:0] rr_code(input logic [3:0] idx);
		case (idx)
			4'd0:    return SEL_VIN;
			4'd1:    return SEL_ICHIP;
			4'd2:    return SEL_IIN;
			4'd3:    return SEL_DIE;
			4'd4:    return SEL_VOUT0;
			4'd5:    return SEL_IOUT0;
			4'd6:    return SEL_TEMP0;
			4'd7:    return SEL_VOUT1;
			4'd8:    return SEL_IOUT1;
			default: return SEL_TEMP1;
		endcase
	endfunction

	// ****************************************************************
	// Stored measurements, peaks and selector
	// ****************************************************************
	logic signed [31:0] vin;          // Compensated input voltage, 2^-8 V
	logic signed [31:0] iin;          // Input current, 2^-8 A
	logic signed [31:0] ichip;        // Chip supply current, 2^-8 A
	logic signed [31:0] die;          // Die temperature, 2^-8 C
	logic signed [31:0] vout [2];     // Output voltage, 2^-12 V
	logic signed [31:0] iout [2];     // Output current, 2^-8 A
	logic signed [31:0] temp [2];     // External temperature, 2^-8 C
	logic signed [31:0] freq [2];     // Switching frequency, kHz
	logic signed [31:0] pout [2];     // Output power, 2^-8 W
	logic signed [31:0] vin_max;      // Peak input voltage
	logic signed [31:0] iin_max;      // Peak input current
	logic signed [31:0] die_max;      // Peak die temperature
	logic signed [31:0] vout_max [2]; // Peak output voltage
	logic signed [31:0] iout_max [2]; // Peak output current
	logic signed [31:0] temp_max [2]; // Peak external temperature
	logic [7:0]         sampling_mode_select;
	logic [SLOT_W-1:0]  slot_cnt;     // Cycles left in this conversion slot
	logic [3:0]         rr_idx;       // Round-robin position

	// ****************************************************************
	// Sample decode and derived quantities
	// ****************************************************************
	wire logic signed [31:0] smp32 = 32'(i_smp_data);
	wire logic               smp_ch = (i_smp_sel >= SEL_VOUT1);
	wire logic hit_vin   = i_smp_valid && (i_smp_sel == SEL_VIN);
	wire logic hit_ichip = i_smp_valid && (i_smp_sel == SEL_ICHIP);
	wire logic hit_iin   = i_smp_valid && (i_smp_sel == SEL_IIN);
	wire logic hit_die   = i_smp_valid && (i_smp_sel == SEL_DIE);
	wire logic hit_vout  = i_smp_valid && (i_smp_sel == SEL_VOUT0 || i_smp_sel == SEL_VOUT1);
	wire logic hit_iout  = i_smp_valid && (i_smp_sel == SEL_IOUT0 || i_smp_sel == SEL_IOUT1);
	wire logic hit_freq  = i_smp_valid && (i_smp_sel == SEL_FREQ0 || i_smp_sel == SEL_FREQ1);
	wire logic hit_temp  = i_smp_valid && (i_smp_sel == SEL_TEMP0 || i_smp_sel == SEL_TEMP1);
	wire logic clr       = i_clear_peaks_command;

	// Pin voltage plus drop across the input filter
	wire logic signed [31:0] vin_new = smp32 +
		mul_shr(ichip, 32'($unsigned(i_input_filter_resistance)), RVIN_SHIFT);
	wire logic signed [31:0] iin_new =
		mul_shr(smp32, 32'($unsigned(i_input_current_sense_gain)), IIN_SHIFT);
	// External sensor gain and offset applied to the raw reading
	wire logic signed [31:0] temp_new =
		mul_shr(smp32, 32'($unsigned(i_external_sensor_gain)), TGAIN_SHIFT) +
		32'(i_external_sensor_offset);
	// Nominal current from sense voltage and conductance
	wire logic signed [31:0] iout_nom =
		mul_shr(smp32, 32'($unsigned(i_current_sense_conductance)), COND_SHIFT);
	// Per-unit drift of the sense element at the channel's temperature
	wire logic signed [31:0] tc_dev =
		mul_shr(32'(i_current_gain_temp_coefficient), temp[smp_ch] - TEMP_REF, TEMP_FRAC);
	wire logic signed [31:0] iout_new = iout_nom - mul_shr(iout_nom, tc_dev, TC_SHIFT);
	// Power from this current and the channel's latest voltage
	wire logic signed [31:0] pout_new = mul_shr(vout[smp_ch], iout_new, POUT_SHIFT);
	wire logic signed [31:0] pin = mul_shr(vin, iin, PIN_SHIFT);

	// ****************************************************************
	// Measurement registers
	// ****************************************************************

	// Unpaged results; die temperature is stored and read, nothing more
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			vin   <= '0;
			iin   <= '0;
			ichip <= '0;
			die   <= '0;
		end else begin
			if (hit_vin) vin <= vin_new;
			if (hit_iin) iin <= iin_new;
			if (hit_ichip) ichip <= smp32;
			if (hit_die) die <= smp32;
		end
	end

	// Paged results, indexed by the sample's channel
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int c = 0; c < 2; c++) begin
				vout[c] <= '0;
				iout[c] <= '0;
				temp[c] <= '0;
				freq[c] <= '0;
				pout[c] <= '0;
			end
		end else begin
			if (hit_vout) vout[smp_ch] <= smp32;
			if (hit_iout) begin
				iout[smp_ch] <= iout_new;
				pout[smp_ch] <= pout_new;
			end
			if (hit_temp) temp[smp_ch] <= temp_new;
			if (hit_freq) freq[smp_ch] <= smp32;
		end
	end

	// ****************************************************************
	// Peak hold
	// ****************************************************************

	// Reads never touch these; only the clear command lowers them
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			vin_max <= PEAK_FLOOR;
			iin_max <= PEAK_FLOOR;
			die_max <= PEAK_FLOOR;
		end else begin
			vin_max <= peak_next(vin_max, clr, hit_vin, vin_new);
			iin_max <= peak_next(iin_max, clr, hit_iin, iin_new);
			die_max <= peak_next(die_max, clr, hit_die, smp32);
		end
	end

	// Per-channel peaks
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			for (int c = 0; c < 2; c++) begin
				vout_max[c] <= PEAK_FLOOR;
				iout_max[c] <= PEAK_FLOOR;
				temp_max[c] <= PEAK_FLOOR;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				vout_max[c] <= peak_next(vout_max[c], clr,
					hit_vout && (smp_ch == c[0]), smp32);
				iout_max[c] <= peak_next(iout_max[c], clr,
					hit_iout && (smp_ch == c[0]), iout_new);
				temp_max[c] <= peak_next(temp_max[c], clr,
					hit_temp && (smp_ch == c[0]), temp_new);
			end
		end
	end

	// ****************************************************************
	// Command decode for reads
	// ****************************************************************
	logic signed [31:0] rd_val;
	logic signed [5:0]  rd_exp;
	ptr_fmt_t           rd_fmt;

	// Select stored value and its encoding by command code
	always_comb begin
		rd_val = '0;
		rd_exp = EXP_FINE;
		rd_fmt = FMT_L11;
		if (i_cmd == CMD_INPUT_VOLTAGE_READING) begin
			rd_val = vin;
		end else if (i_cmd == CMD_INPUT_CURRENT_READING) begin
			rd_val = iin;
		end else if (i_cmd == CMD_OUTPUT_VOLTAGE_READING) begin
			rd_val = vout[i_page];
			rd_fmt = FMT_L16;
		end else if (i_cmd == CMD_OUTPUT_CURRENT_READING) begin
			rd_val = iout[i_page];
		end else if (i_cmd == CMD_EXTERNAL_TEMPERATURE_READING) begin
			rd_val = temp[i_page];
		end else if (i_cmd == CMD_DIE_TEMPERATURE_READING) begin
			rd_val = die;
		end else if (i_cmd == CMD_SWITCHING_FREQUENCY_READING) begin
			rd_val = freq[i_page];
			rd_exp = EXP_FREQ;
		end else if (i_cmd == CMD_OUTPUT_POWER_READING) begin
			rd_val = pout[i_page];
		end else if (i_cmd == CMD_INPUT_POWER_READING) begin
			rd_val = pin;
		end else if (i_cmd == CMD_OUTPUT_CURRENT_MAXIMUM) begin
			rd_val = iout_max[i_page];
		end else if (i_cmd == CMD_SAMPLING_MODE_SELECT) begin
			rd_val = {24'h000000, sampling_mode_select};
			rd_fmt = FMT_BYTE;
		end else if (i_cmd == CMD_OUTPUT_VOLTAGE_MAXIMUM) begin
			rd_val = vout_max[i_page];
			rd_fmt = FMT_L16;
		end else if (i_cmd == CMD_INPUT_VOLTAGE_MAXIMUM) begin
			rd_val = vin_max;
		end else if (i_cmd == CMD_EXTERNAL_TEMPERATURE_MAXIMUM) begin
			rd_val = temp_max[i_page];
		end else if (i_cmd == CMD_INPUT_CURRENT_MAXIMUM) begin
			rd_val = iin_max;
		end else if (i_cmd == CMD_CHIP_SUPPLY_CURRENT) begin
			rd_val = ichip;
		end else if (i_cmd == CMD_DIE_TEMPERATURE_MAXIMUM) begin
			rd_val = die_max;
		end else begin
			rd_fmt = FMT_NONE; // Unsupported code
		end
	end

	wire logic [15:0] rd_word = (rd_fmt == FMT_L16) ? enc_l16(rd_val, i_vout_mode_exponent) :
		(rd_fmt == FMT_L11) ? enc_l11(rd_val, rd_exp) : rd_val[15:0];
	wire logic [1:0]  rd_bytes = (rd_fmt == FMT_BYTE) ? BYTES_BYTE :
		(rd_fmt == FMT_NONE) ? BYTES_NONE : BYTES_WORD;
	wire logic        rd_ok = i_rd_req && (rd_fmt != FMT_NONE);
	wire logic        wr_sel = i_wr_req && (i_cmd == CMD_SAMPLING_MODE_SELECT);
	// Writes to any result code are refused
	wire logic        cmd_bad = (i_rd_req && !rd_ok) || (i_wr_req && !wr_sel);

	// ****************************************************************
	// Read answer and write handling
	// ****************************************************************

	// Whole word latched in one edge so both bytes share a sample
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rd_ack        <= 1'b0;
			o_rd_data       <= 16'h0000;
			o_rd_byte_count <= BYTES_NONE;
			o_cmd_err       <= 1'b0;
		end else begin
			o_rd_ack  <= rd_ok;
			o_cmd_err <= cmd_bad;
			if (rd_ok) begin
				o_rd_data       <= rd_word;
				o_rd_byte_count <= rd_bytes;
			end
		end
	end

	// Selector byte, the only writable location
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sampling_mode_select <= SAMPLING_MODE_RESET;
		end else if (wr_sel) begin
			sampling_mode_select <= i_wr_data;
		end
	end

	// ****************************************************************
	// Conversion scheduling
	// ****************************************************************
	wire logic sel_valid = (sampling_mode_select[7:4] == 4'h0) &&
		(sampling_mode_select[3:0] <= SEL_TEMP1) &&
		(sampling_mode_select[3:0] != SEL_FREQ0) &&
		(sampling_mode_select[3:0] != SEL_FREQ1);
	wire ptr_mode_t mode = (sampling_mode_select == SAMPLING_MODE_RESET) ? MODE_ROUND_ROBIN :
		sel_valid ? MODE_SINGLE : MODE_FALLBACK;
	logic [3:0]        conv_next;
	logic [SLOT_W-1:0] slot_load;

	// Parameter and slot length for the next conversion
	always_comb begin
		case (mode)
			MODE_ROUND_ROBIN: begin
				conv_next = rr_code(rr_idx);
				slot_load = SLOT_W'(P_RR_SLOT_CYC - 1);
			end
			MODE_SINGLE: begin
				conv_next = sampling_mode_select[3:0];
				slot_load = SLOT_W'(P_FAST_SLOT_CYC - 1);
			end
			default: begin
				conv_next = SEL_DIE;
				slot_load = SLOT_W'(P_FAST_SLOT_CYC - 1);
			end
		endcase
	end

	// Slot timer; a start pulse each time it runs out
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slot_cnt     <= '0;
			rr_idx       <= 4'd0;
			o_conv_start <= 1'b0;
			o_conv_sel   <= SEL_ROUND_ROBIN;
		end else begin
			o_conv_start <= (slot_cnt == '0);
			if (slot_cnt == '0) begin
				slot_cnt   <= slot_load;
				o_conv_sel <= conv_next;
				if (mode == MODE_ROUND_ROBIN) begin
					rr_idx <= (rr_idx == RR_LAST) ? 4'd0 : rr_idx + 4'd1;
				end
			end else begin
				slot_cnt <= slot_cnt - SLOT_W'(1);
			end
		end
	end

	// Fault stands as long as a reserved value is held
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cml_fault <= 1'b0;
		end else begin
			o_cml_fault <= (mode == MODE_FALLBACK);
		end
	end

endmodule

/* ptr_telemetry_readback_test.sv */
`timescale 1ns/100ps
module ptr_telemetry_readback_test
	import ptr_pkg::*;
;
	logic i_clk, i_rst, i_rd_req, i_wr_req, i_page, i_clear_peaks_command;
	logic o_rd_ack, o_cmd_err, o_cml_fault, o_conv_start, smp_valid;
	logic [7:0] i_cmd, i_wr_data;
	logic [15:0] o_rd_data, unity, zero;
	logic [1:0] o_rd_byte_count;
	logic [3:0] conv_sel, smp_sel;
	logic signed [15:0] smp_data, model_val;
	int bad_count, compares, cycles;
	ptr_telemetry_readback #(.P_RR_SLOT_CYC(20), .P_FAST_SLOT_CYC(16)) u_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_rd_req(i_rd_req), .i_wr_req(i_wr_req),
		.i_cmd(i_cmd), .i_page(i_page), .i_wr_data(i_wr_data),
		.i_clear_peaks_command(i_clear_peaks_command), .o_rd_ack(o_rd_ack),
		.o_rd_data(o_rd_data), .o_rd_byte_count(o_rd_byte_count), .o_cmd_err(o_cmd_err),
		.o_cml_fault(o_cml_fault), .i_smp_valid(smp_valid), .i_smp_sel(smp_sel),
		.i_smp_data(smp_data), .o_conv_start(o_conv_start), .o_conv_sel(conv_sel),
		.i_input_filter_resistance(unity), .i_input_current_sense_gain(unity),
		.i_current_sense_conductance(unity), .i_current_gain_temp_coefficient(zero),
		.i_external_sensor_gain({unity[13:0], 2'b00}), .i_external_sensor_offset(zero),
		.i_vout_mode_exponent(5'h14));
	ptr_front_model u_front (.i_clk(i_clk), .i_rst(i_rst), .i_conv_start(o_conv_start),
		.i_conv_sel(conv_sel), .i_value(model_val), .o_smp_valid(smp_valid),
		.o_smp_sel(smp_sel), .o_smp_data(smp_data));
	// Compare and count
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	// One read: request on an edge, answer looked at in the following cycle
	task automatic rd(input logic [7:0] cmd, input logic pg, input logic [15:0] exp);
		i_rd_req <= 1'b1;
		i_cmd <= cmd;
		i_page <= pg;
		@(posedge i_clk);
		i_rd_req <= 1'b0;
		#1;
		check("ack", {15'h0, o_rd_ack}, 16'h0001);
		check("count", {14'h0, o_rd_byte_count}, (cmd == 8'hd8) ? 16'h0001 : 16'h0002);
		check("data", (cmd == 8'hd8) ? {8'h00, o_rd_data[7:0]} : o_rd_data, exp);
		@(posedge i_clk);
	endtask
	// A request that must be refused with an error and no acknowledge
	task automatic refuse(input logic wr, input logic [7:0] cmd);
		i_rd_req <= !wr;
		i_wr_req <= wr;
		i_cmd <= cmd;
		@(posedge i_clk);
		i_rd_req <= 1'b0;
		i_wr_req <= 1'b0;
		#1;
		check("error", {14'h0, o_cmd_err, o_rd_ack}, 16'h0002);
		@(posedge i_clk);
	endtask
	// Selector write, then a pause for the new mode to take over
	task automatic wr(input logic [7:0] data, input int gap);
		i_wr_req <= 1'b1;
		i_cmd <= CMD_SAMPLING_MODE_SELECT;
		i_wr_data <= data;
		@(posedge i_clk);
		i_wr_req <= 1'b0;
		repeat (gap) @(posedge i_clk);
	endtask
	task automatic end_of_test();
		$display("compares %0d, bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// Hang guard: the sequence needs well under a thousand cycles
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			end_of_test();
		end
	end
	initial begin
		{i_rst, i_rd_req, i_wr_req, i_page, i_clear_peaks_command} = 5'b10000;
		{i_cmd, i_wr_data, unity, zero, model_val} = {16'h0000, 16'h1000, 16'h0000, 16'h1234};
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'hd8, 1'b0, 16'h0000);
		wr(8'h05, 60);
		rd(8'h8b, 1'b0, 16'h1234);
		rd(8'hdd, 1'b0, 16'h1234);
		model_val <= 16'sh0100;
		repeat (40) @(posedge i_clk);
		rd(8'h8b, 1'b0, 16'h0100);
		rd(8'hdd, 1'b0, 16'h1234);
		wr(8'h04, 40);
		rd(8'h8e, 1'b1, 16'hc100);
		rd(8'hf4, 1'b0, 16'hc100);
		rd(8'hd8, 1'b0, 16'h0004);
		i_clear_peaks_command <= 1'b1;
		@(posedge i_clk);
		i_clear_peaks_command <= 1'b0;
		@(posedge i_clk);
		rd(8'hdd, 1'b0, 16'h0000);
		rd(8'hde, 1'b0, 16'h6c00);
		refuse(1'b0, 8'h00);
		refuse(1'b1, 8'h88);
		wr(8'h02, 40);
		rd(8'he4, 1'b0, 16'hc100);
		wr(8'h01, 40);
		rd(8'h88, 1'b0, 16'hca80);
		rd(8'hde, 1'b0, 16'hca80);
		wr(8'h03, 40);
		rd(8'h89, 1'b0, 16'hc100);
		rd(8'h97, 1'b0, 16'hca80);
		rd(8'he1, 1'b0, 16'hc100);
		wr(8'h06, 40);
		rd(8'h8c, 1'b0, 16'hc001);
		rd(8'hd7, 1'b0, 16'hc001);
		rd(8'h96, 1'b0, 16'hc000);
		wr(8'h08, 40);
		rd(8'h8d, 1'b0, 16'hc100);
		rd(8'hdf, 1'b0, 16'hc100);
		wr(8'h0f, 2);
		#1 check("fault", {15'h0, o_cml_fault}, 16'h0001);
		@(posedge i_clk);
		wr(8'h00, 2);
		#1 check("fault", {15'h0, o_cml_fault}, 16'h0000);
		end_of_test();
	end
endmodule
bind ptr_telemetry_readback ptr_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_rd_req(i_rd_req),
	.i_wr_req(i_wr_req), .i_cmd(i_cmd), .i_wr_data(i_wr_data), .o_rd_ack(o_rd_ack),
	.o_rd_data(o_rd_data), .o_rd_byte_count(o_rd_byte_count), .o_cmd_err(o_cmd_err),
	.o_cml_fault(o_cml_fault), .o_conv_start(o_conv_start));
